// ===== common/swct_defines.svh
`ifndef SWCT_DEFINES_SVH
`define SWCT_DEFINES_SVH
// word indexes; the bus byte address is four times the index
`define SWCT_OFF_TRIM 8'h31
`define SWCT_OFF_CTRL 8'h35
`define SWCT_OFF_STAT 8'h10
`define SWCT_OFF_IRQ 8'h11
`define SWCT_CTRL_RMASK 8'h7B
`define SWCT_TRIM_RST 8'h00
`define SWCT_CTRL_RST 8'h00
`define SWCT_CTRL_ARM 5
`define SWCT_CTRL_SELHI 4
`define SWCT_CTRL_SELLO 3
`define SWCT_CTRL_SENHI 1
`define SWCT_CTRL_SENLO 0
`define SWCT_IRQ_GIE 0
`define SWCT_IRQ_EXT 1
`define SWCT_IRQ_PC 2
`define SWCT_WAKE_STALL 3'h4
`define SWCT_PC_DELAY 2'h2
`define SWCT_PLL_MULT 5'h10
`define SWCT_RC_KHZ 1600
`define SWCT_CLK_KHZ 25000
`endif

// ===== common/swct_pkg.sv
package swct_pkg;
    typedef enum logic [1:0] {
        SWCT_IDLE = 2'h0,
        SWCT_ADCNR = 2'h1,
        SWCT_PDOWN = 2'h2,
        SWCT_RSVD = 2'h3
    } swct_mode_t;
    typedef enum logic [1:0] {
        SWCT_LOW = 2'h0,
        SWCT_ANY = 2'h1,
        SWCT_FALL = 2'h2,
        SWCT_RISE = 2'h3
    } swct_sense_t;
    typedef enum logic [4:0] {
        SWCT_RUN = 5'h01,
        SWCT_SLEEP = 5'h02,
        SWCT_SETTLE = 5'h04,
        SWCT_STALL = 5'h08,
        SWCT_HANDLE = 5'h10
    } swct_state_t;
    typedef struct packed {
        logic wdt_timeout;
        logic wdt_reset;
        logic adc_irq;
        logic other_irq;
    } swct_wake_t;
endpackage

// ===== src/swct_sync.sv
`timescale 1ns/1ps
module swct_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_ff;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_ff <= 1'b1;
            q_o <= 1'b1;
        end else begin
            s1_ff <= d_i;
            q_o <= s1_ff;
        end
    end
endmodule

// ===== src/swct_wdtq.sv
`timescale 1ns/1ps
// two watchdog-tick samples must agree before the wake is believed
module swct_wdtq (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic cond_i,
    output logic ok_o
);
    logic [1:0] hist_ff;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hist_ff <= 2'h0;
        end else if (!cond_i) begin
            hist_ff <= 2'h0;
        end else if (tick_i) begin
            hist_ff <= {hist_ff[0], 1'b1};
        end
    end
    assign ok_o = hist_ff[1] & cond_i;
endmodule

// ===== src/swct_top.sv
`timescale 1ns/1ps
`include "swct_defines.svh"
// How it works
// - sleep selector: 00 idle, 01 adc noise reduction, 10 power-down, 11 reserved.
// - control word bit 2 always reads zero.
// - sense: 00 low level, 01 any change, 10 falling, 11 rising.
// - external interrupt taken only with global enable and its mask set.
// - sleep only on halt with arm bit set; selector picks state.
// - enabled interrupt wakes, stalls four cycles, then handler, then resume.
// - pin-change wake from power-down: two cycles before flag updates.
// - register, sram and io contents kept across sleep.
// - reset during sleep restarts at the reset vector.
// - idle stops only the cpu; all else runs and may wake.
// - enabled adc starts converting on entering idle or noise reduction.
// - noise reduction stops cpu; adc, pins, watchdog, clock, pll run.
// - noise reduction wakes on watchdog, reset, level ext, pin change, adc.
// - power-down wakes on reset, watchdog reset, level ext, pin change.
// - power-down level wakes need two watchdog-tick samples agreeing.
// - power-down exit waits a fuse-chosen settle delay.
// - trim resets to zero; larger trim means faster oscillator.
// - pll makes 16x rc clock for the second timer.
// - pll follows trim, so trim moves the fast clock.
// - rc oscillator is always the system clock.
// - level-sensed ext interrupt requests while the pin stays low.
module swct_top #(
    parameter int SETTLE_W = 16
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic HALT_I,
    input wire logic EXT_IRQ_PIN_I,
    input wire logic PIN_CHANGE_I,
    input wire logic WDT_TICK_I,
    input wire logic ADC_EN_I,
    input wire logic [SETTLE_W-1:0] CLOCK_DELAY_FUSES_I,
    input wire swct_pkg::swct_wake_t WAKE_I,
    output logic CPU_STOP_O,
    output logic CLK_STOP_O,
    output logic IRQ_TAKE_O,
    output logic PC_FLAG_SET_O,
    output logic ADC_START_O,
    output logic [7:0] RC_TRIM_O,
    output logic [4:0] PLL_MULT_O,
    output logic [1:0] MODE_O
);
    if (SETTLE_W < 2 || SETTLE_W > 24) begin : g_bad_settle
        $error("SETTLE_W out of range");
    end
    // rc stays system clock; pll fed by it so trim moves both
    localparam int PCK_KHZ = `SWCT_RC_KHZ * 16;

    logic [7:0] trim_ff;
    logic [7:0] ctrl_ff;
    logic [2:0] irqen_ff;
    swct_pkg::swct_state_t state_ff;
    swct_pkg::swct_mode_t mode_ff;
    logic [SETTLE_W-1:0] settle_ff;
    logic [2:0] stall_ff;
    logic [1:0] pcdly_ff;
    logic pc_wake_ff;
    logic ext_req_ff;
    logic ext_prev_ff;
    logic ext_s;
    logic pc_s;
    logic q_level_ok;
    logic q_pc_ok;
    logic aw_ff;
    logic w_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wen_ff;
    logic [7:0] rdata;

    function automatic logic [7:0] rd_reg(input logic [7:0] a);
        unique case (a)
            `SWCT_OFF_TRIM: rd_reg = trim_ff;
            `SWCT_OFF_CTRL: rd_reg = ctrl_ff & `SWCT_CTRL_RMASK;
            `SWCT_OFF_STAT: rd_reg = {3'h0, state_ff};
            `SWCT_OFF_IRQ: rd_reg = {5'h0, irqen_ff};
            default: rd_reg = 8'h00;
        endcase
    endfunction

    function automatic logic known(input logic [7:0] a);
        known = (a == `SWCT_OFF_TRIM) || (a == `SWCT_OFF_CTRL) ||
            (a == `SWCT_OFF_STAT) || (a == `SWCT_OFF_IRQ);
    endfunction

    swct_sync u_ext (.clk_i(CLK_I), .rst_i(RST_I), .d_i(EXT_IRQ_PIN_I), .q_o(ext_s));
    swct_sync u_pc (.clk_i(CLK_I), .rst_i(RST_I), .d_i(PIN_CHANGE_I), .q_o(pc_s));

    swct_pkg::swct_sense_t sense;
    swct_pkg::swct_mode_t sel;
    logic sleeping;
    logic ext_lvl;
    logic ext_evt;
    logic ext_ok;
    logic pc_ok;
    logic ext_wake;
    logic pc_wake;
    logic wake;
    assign sense = swct_pkg::swct_sense_t'(ctrl_ff[`SWCT_CTRL_SENHI:`SWCT_CTRL_SENLO]);
    assign sel = swct_pkg::swct_mode_t'(ctrl_ff[`SWCT_CTRL_SELHI:`SWCT_CTRL_SELLO]);
    assign sleeping = (state_ff == swct_pkg::SWCT_SLEEP);
    assign ext_lvl = !ext_s;

    always_comb begin
        unique case (sense)
            swct_pkg::SWCT_LOW: ext_evt = ext_lvl;
            swct_pkg::SWCT_ANY: ext_evt = ext_s ^ ext_prev_ff;
            swct_pkg::SWCT_FALL: ext_evt = ext_prev_ff & !ext_s;
            swct_pkg::SWCT_RISE: ext_evt = !ext_prev_ff & ext_s;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ext_prev_ff <= 1'b1;
        end else begin
            ext_prev_ff <= ext_s;
        end
    end

    // request latch for edges; level mode tracks the pin directly
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ext_req_ff <= 1'b0;
        end else if (sense == swct_pkg::SWCT_LOW) begin
            ext_req_ff <= ext_lvl;
        end else if (ext_evt) begin
            ext_req_ff <= 1'b1; // set beats the clear below
        end else if (IRQ_TAKE_O) begin
            ext_req_ff <= 1'b0;
        end
    end

    assign ext_ok = irqen_ff[`SWCT_IRQ_GIE] & irqen_ff[`SWCT_IRQ_EXT];
    assign pc_ok = irqen_ff[`SWCT_IRQ_GIE] & irqen_ff[`SWCT_IRQ_PC];

    swct_wdtq u_qext (.clk_i(CLK_I), .rst_i(RST_I), .tick_i(WDT_TICK_I),
        .cond_i(ext_lvl & ext_ok & (sense == swct_pkg::SWCT_LOW)), .ok_o(q_level_ok));
    swct_wdtq u_qpc (.clk_i(CLK_I), .rst_i(RST_I), .tick_i(WDT_TICK_I),
        .cond_i(pc_s & pc_ok), .ok_o(q_pc_ok));

    always_comb begin
        ext_wake = 1'b0;
        pc_wake = 1'b0;
        wake = 1'b0;
        unique case (mode_ff)
            swct_pkg::SWCT_IDLE: begin
                ext_wake = ext_req_ff & ext_ok;
                pc_wake = pc_s & pc_ok;
                wake = ext_wake | pc_wake | WAKE_I.wdt_timeout | WAKE_I.wdt_reset |
                    WAKE_I.adc_irq | WAKE_I.other_irq;
            end
            swct_pkg::SWCT_ADCNR: begin
                ext_wake = ext_lvl & ext_ok & (sense == swct_pkg::SWCT_LOW);
                pc_wake = pc_s & pc_ok;
                wake = ext_wake | pc_wake | WAKE_I.wdt_timeout | WAKE_I.adc_irq;
            end
            swct_pkg::SWCT_PDOWN: begin
                ext_wake = q_level_ok;
                pc_wake = q_pc_ok;
                wake = ext_wake | pc_wake | WAKE_I.wdt_reset;
            end
            swct_pkg::SWCT_RSVD: begin
                wake = 1'b1;
            end
        endcase
    end

    // reset acts through RST_I, so sleep always restarts at the vector
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_ff <= swct_pkg::SWCT_RUN;
            mode_ff <= swct_pkg::SWCT_IDLE;
            settle_ff <= '0;
            stall_ff <= 3'h0;
            pc_wake_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                swct_pkg::SWCT_RUN: begin
                    if (HALT_I && ctrl_ff[`SWCT_CTRL_ARM] && sel != swct_pkg::SWCT_RSVD) begin
                        state_ff <= swct_pkg::SWCT_SLEEP;
                        mode_ff <= sel;
                    end
                end
                swct_pkg::SWCT_SLEEP: begin
                    if (wake) begin
                        pc_wake_ff <= pc_wake && mode_ff == swct_pkg::SWCT_PDOWN;
                        if (mode_ff == swct_pkg::SWCT_PDOWN) begin
                            state_ff <= swct_pkg::SWCT_SETTLE;
                            settle_ff <= CLOCK_DELAY_FUSES_I;
                        end else begin
                            state_ff <= swct_pkg::SWCT_STALL;
                            stall_ff <= `SWCT_WAKE_STALL - 3'h1;
                        end
                    end
                end
                swct_pkg::SWCT_SETTLE: begin
                    if (settle_ff == '0) begin
                        state_ff <= swct_pkg::SWCT_STALL;
                        stall_ff <= `SWCT_WAKE_STALL - 3'h1;
                    end else begin
                        settle_ff <= settle_ff - 1'b1;
                    end
                end
                swct_pkg::SWCT_STALL: begin
                    if (stall_ff == 3'h0) begin
                        state_ff <= swct_pkg::SWCT_HANDLE;
                    end else begin
                        stall_ff <= stall_ff - 3'h1;
                    end
                end
                swct_pkg::SWCT_HANDLE: begin
                    state_ff <= swct_pkg::SWCT_RUN;
                    pc_wake_ff <= 1'b0;
                end
                default: state_ff <= swct_pkg::SWCT_RUN;
            endcase
        end
    end

    // two run cycles after pin-change wake before the flag moves
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pcdly_ff <= 2'h0;
        end else if (state_ff == swct_pkg::SWCT_HANDLE && pc_wake_ff) begin
            pcdly_ff <= `SWCT_PC_DELAY;
        end else if (pcdly_ff != 2'h0) begin
            pcdly_ff <= pcdly_ff - 2'h1;
        end
    end
    assign PC_FLAG_SET_O = (pcdly_ff == 2'h1);

    assign IRQ_TAKE_O = (state_ff == swct_pkg::SWCT_HANDLE) ||
        (state_ff == swct_pkg::SWCT_RUN && ext_req_ff && ext_ok);
    // clocks only stop in power-down; memories untouched by sleep
    assign CPU_STOP_O = !(state_ff == swct_pkg::SWCT_RUN || state_ff == swct_pkg::SWCT_HANDLE);
    assign CLK_STOP_O = sleeping && mode_ff == swct_pkg::SWCT_PDOWN;
    assign MODE_O = mode_ff;
    assign RC_TRIM_O = trim_ff;
    assign PLL_MULT_O = `SWCT_PLL_MULT;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ADC_START_O <= 1'b0;
        end else begin
            ADC_START_O <= ADC_EN_I && state_ff == swct_pkg::SWCT_RUN && HALT_I &&
                ctrl_ff[`SWCT_CTRL_ARM] && (sel == swct_pkg::SWCT_IDLE ||
                sel == swct_pkg::SWCT_ADCNR);
        end
    end

    // axi4-lite: hold address and data until both arrive
    logic do_wr;
    assign do_wr = aw_ff && w_ff && !S_AXI_BVALID;
    assign S_AXI_AWREADY = !aw_ff && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_ff && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wen_ff <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR[9:2];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA[7:0];
                wen_ff <= S_AXI_WSTRB[0];
            end
            if (do_wr) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= known(awaddr_ff) ? 2'h0 : 2'h2;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // writes ignoring strobe 0 are treated as no change
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            trim_ff <= `SWCT_TRIM_RST;
            ctrl_ff <= `SWCT_CTRL_RST;
            irqen_ff <= 3'h0;
        end else if (do_wr && wen_ff) begin
            unique case (awaddr_ff)
                `SWCT_OFF_TRIM: trim_ff <= wdata_ff;
                `SWCT_OFF_CTRL: ctrl_ff <= wdata_ff & `SWCT_CTRL_RMASK;
                `SWCT_OFF_IRQ: irqen_ff <= wdata_ff[2:0];
                default: ;
            endcase
        end
    end

    assign rdata = rd_reg(S_AXI_ARADDR[9:2]);
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'h0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {24'h00_0000, rdata};
            S_AXI_RRESP <= known(S_AXI_ARADDR[9:2]) ? 2'h0 : 2'h2;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    property p_stall4;
        @(posedge CLK_I) disable iff (RST_I)
        $rose(state_ff == swct_pkg::SWCT_STALL) |-> (state_ff == swct_pkg::SWCT_STALL) [*4]
            ##1 state_ff == swct_pkg::SWCT_HANDLE;
    endproperty
    a_stall4: assert property (p_stall4) else $error("stall not four cycles");
    property p_rsvd;
        @(posedge CLK_I) disable iff (RST_I)
        state_ff == swct_pkg::SWCT_RUN && sel == swct_pkg::SWCT_RSVD |=>
            state_ff == swct_pkg::SWCT_RUN;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode slept");
    property p_arm;
        @(posedge CLK_I) disable iff (RST_I)
        state_ff == swct_pkg::SWCT_RUN && !(HALT_I && ctrl_ff[`SWCT_CTRL_ARM]) |=>
            state_ff == swct_pkg::SWCT_RUN;
    endproperty
    a_arm: assert property (p_arm) else $error("slept without arm and halt");
    property p_bit2;
        @(posedge CLK_I) disable iff (RST_I) ctrl_ff[2] == 1'b0;
    endproperty
    a_bit2: assert property (p_bit2) else $error("control bit 2 set");
    property p_pcflag;
        @(posedge CLK_I) disable iff (RST_I)
        state_ff == swct_pkg::SWCT_HANDLE && pc_wake_ff |-> ##2 PC_FLAG_SET_O;
    endproperty
    a_pcflag: assert property (p_pcflag) else $error("pin flag timing");
    property p_pdwake;
        @(posedge CLK_I) disable iff (RST_I)
        sleeping && mode_ff == swct_pkg::SWCT_PDOWN && !q_level_ok && !q_pc_ok &&
            !WAKE_I.wdt_reset |=> sleeping;
    endproperty
    a_pdwake: assert property (p_pdwake) else $error("bad power-down wake");
    property p_nrwake;
        @(posedge CLK_I) disable iff (RST_I)
        sleeping && mode_ff == swct_pkg::SWCT_ADCNR && !ext_wake && !pc_wake &&
            !WAKE_I.wdt_timeout && !WAKE_I.adc_irq |=> sleeping;
    endproperty
    a_nrwake: assert property (p_nrwake) else $error("bad noise-reduction wake");
    property p_mask;
        @(posedge CLK_I) disable iff (RST_I)
        state_ff == swct_pkg::SWCT_RUN && !irqen_ff[`SWCT_IRQ_GIE] |-> !IRQ_TAKE_O;
    endproperty
    a_mask: assert property (p_mask) else $error("irq taken while disabled");
    property p_settle;
        @(posedge CLK_I) disable iff (RST_I)
        state_ff == swct_pkg::SWCT_SETTLE && settle_ff != '0 |=>
            state_ff == swct_pkg::SWCT_SETTLE;
    endproperty
    a_settle: assert property (p_settle) else $error("settle cut short");
    c_idle: cover property (@(posedge CLK_I) disable iff (RST_I)
        sleeping && mode_ff == swct_pkg::SWCT_IDLE ##1 state_ff == swct_pkg::SWCT_STALL);
    c_pd: cover property (@(posedge CLK_I) disable iff (RST_I)
        state_ff == swct_pkg::SWCT_SETTLE ##1 state_ff == swct_pkg::SWCT_STALL);
    c_pc: cover property (@(posedge CLK_I) disable iff (RST_I) PC_FLAG_SET_O);
endmodule

// ===== tb/swct_far.sv
`timescale 1ns/1ps
// core side: halt strobe one cycle after the request, watchdog oscillator ticks
module swct_far (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic halt_req_i,
    output logic halt_o,
    output logic tick_o
);
    logic [2:0] div_ff;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_ff <= 3'h0;
            halt_o <= 1'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
            halt_o <= halt_req_i;
        end
    end
    // slow oscillator, so a short pin pulse cannot span two ticks
    assign tick_o = (div_ff == 3'h7);
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "swct_defines.svh"
module testbench;
    logic clk, rst, aw_v, w_v, b_rdy, ar_v, r_rdy, halt_req, ext_lvl, pc_lvl, adc_en;
    logic aw_r, w_r, b_v, ar_r, r_v, halt, tick, cpu_stop, clk_stop, irq_take, pc_set, adc_st;
    logic [31:0] aw_a, w_d, ar_a, r_d, d;
    logic [1:0] b_resp, r_resp, mode, rr;
    logic [7:0] trim;
    logic [4:0] mult;
    swct_pkg::swct_wake_t wake;
    int mismatches, cmp_count, adc_seen, n0;
    swct_top #(.SETTLE_W(4)) u_dut (
        .CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v),
        .S_AXI_AWREADY(aw_r), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v),
        .S_AXI_WREADY(w_r), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_rdy),
        .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_r), .S_AXI_RDATA(r_d),
        .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_rdy), .HALT_I(halt),
        .EXT_IRQ_PIN_I(ext_lvl), .PIN_CHANGE_I(pc_lvl), .WDT_TICK_I(tick), .ADC_EN_I(adc_en),
        .CLOCK_DELAY_FUSES_I(4'h3), .WAKE_I(wake), .CPU_STOP_O(cpu_stop),
        .CLK_STOP_O(clk_stop), .IRQ_TAKE_O(irq_take), .PC_FLAG_SET_O(pc_set),
        .ADC_START_O(adc_st), .RC_TRIM_O(trim), .PLL_MULT_O(mult), .MODE_O(mode)
    );
    swct_far u_far (.clk_i(clk), .rst_i(rst), .halt_req_i(halt_req), .halt_o(halt),
        .tick_o(tick));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // pulse is one cycle wide, so count it rather than hunt for it
    always @(posedge clk) if (adc_st === 1'h1) adc_seen++;
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        mismatches++;
        $display("wait ran out at %0t", $time);
        summarize();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_hi(ref logic s);
        int n;
        for (n = 0; n < 300 && s !== 1'h1; n++) @(posedge clk);
        if (n == 300) tmo();
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        int n;
        aw_a <= {22'h0, a, 2'h0};
        w_d <= v;
        aw_v <= 1'h1;
        w_v <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            if (aw_v && aw_r === 1'h1) aw_v <= 1'h0;
            if (w_v && w_r === 1'h1) w_v <= 1'h0;
            n++;
        end while (n < 50 && b_v !== 1'h1);
        if (b_v !== 1'h1) tmo();
        rr = b_resp;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v);
        int n;
        ar_a <= {22'h0, a, 2'h0};
        ar_v <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            if (ar_v && ar_r === 1'h1) ar_v <= 1'h0;
            n++;
        end while (n < 50 && r_v !== 1'h1);
        if (r_v !== 1'h1) tmo();
        v = r_d;
        rr = r_resp;
    endtask
    task automatic sleep_now(input logic [31:0] ctrl);
        axw(`SWCT_OFF_CTRL, ctrl);
        halt_req <= 1'h1;
        @(posedge clk);
        halt_req <= 1'h0;
        cyc(3);
    endtask
    task automatic t_regs();
        axr(`SWCT_OFF_TRIM, d);
        chk(d, 32'h0);
        chk(mult, 32'h10);
        axw(`SWCT_OFF_CTRL, 32'hFF);
        axr(`SWCT_OFF_CTRL, d);
        chk(d, 32'h7B);
        axw(`SWCT_OFF_TRIM, 32'hFF);
        chk(trim, 32'hFF);
        axw(8'h20, 32'h1);
        chk(rr, 32'h2);
        axr(8'h20, d);
        chk(rr, 32'h2);
        axw(`SWCT_OFF_TRIM, 32'h5A);
        $display("registers done");
    endtask
    task automatic t_noop();
        sleep_now(32'h38);
        chk(cpu_stop, 32'h0);
        sleep_now(32'h10);
        chk(cpu_stop, 32'h0);
        $display("no-sleep halts done");
    endtask
    task automatic t_ext();
        int s;
        axw(`SWCT_OFF_CTRL, 32'h0);
        axw(`SWCT_OFF_IRQ, 32'h1);
        ext_lvl <= 1'h0;
        cyc(5);
        chk(irq_take, 32'h0);
        axw(`SWCT_OFF_IRQ, 32'h2);
        cyc(5);
        chk(irq_take, 32'h0);
        axw(`SWCT_OFF_IRQ, 32'h3);
        cyc(5);
        chk(irq_take, 32'h1);
        cyc(5);
        chk(irq_take, 32'h1);
        for (s = 1; s < 4; s++) begin
            axw(`SWCT_OFF_IRQ, 32'h1);
            ext_lvl <= (s == 3) ? 1'h0 : 1'h1;
            axw(`SWCT_OFF_CTRL, s);
            axw(`SWCT_OFF_IRQ, 32'h3);
            cyc(4);
            chk(irq_take, 32'h0);
            ext_lvl <= ~ext_lvl;
            @(posedge clk);
            wait_hi(irq_take);
        end
        axw(`SWCT_OFF_IRQ, 32'h0);
        ext_lvl <= 1'h1;
        axw(`SWCT_OFF_CTRL, 32'h0);
        $display("external interrupt done");
    endtask
    task automatic t_wake(input logic [1:0] m);
        axw(`SWCT_OFF_IRQ, 32'h1);
        n0 = adc_seen;
        sleep_now(32'h20 | (m << 3));
        chk(cpu_stop, 32'h1);
        chk(mode, m);
        chk(clk_stop, 32'h0);
        axr(`SWCT_OFF_STAT, d);
        chk(d, 32'h2);
        cyc(2);
        chk(adc_seen - n0, 32'h1);
        wake.adc_irq <= 1'h1;
        repeat (5) begin
            @(posedge clk);
            chk(irq_take, 32'h0);
        end
        @(posedge clk);
        chk(irq_take, 32'h1);
        cyc(2);
        chk(cpu_stop, 32'h0);
        wake.adc_irq <= 1'h0;
        axr(`SWCT_OFF_TRIM, d);
        chk(d, 32'h5A);
        axr(`SWCT_OFF_CTRL, d);
        chk(d, 32'h20 | (m << 3));
        $display("light sleep done");
    endtask
    task automatic t_pdown();
        axw(`SWCT_OFF_IRQ, 32'h5);
        sleep_now(32'h30);
        chk(clk_stop, 32'h1);
        chk(mode, 32'h2);
        wake.adc_irq <= 1'h1;
        cyc(20);
        chk(cpu_stop, 32'h1);
        wake.adc_irq <= 1'h0;
        pc_lvl <= 1'h1;
        cyc(3);
        pc_lvl <= 1'h0;
        cyc(30);
        chk(cpu_stop, 32'h1);
        pc_lvl <= 1'h1;
        wait_hi(irq_take);
        @(posedge clk);
        chk(pc_set, 32'h0);
        @(posedge clk);
        chk(pc_set, 32'h1);
        pc_lvl <= 1'h0;
        axw(`SWCT_OFF_IRQ, 32'h0);
        $display("power-down done");
    endtask
    task automatic t_reset();
        adc_en <= 1'h0;
        n0 = adc_seen;
        sleep_now(32'h20);
        chk(cpu_stop, 32'h1);
        chk(adc_seen - n0, 32'h0);
        rst <= 1'h1;
        cyc(2);
        chk(cpu_stop, 32'h0);
        chk(trim, 32'h0);
        rst <= 1'h0;
        cyc(2);
        $display("reset in sleep done");
    endtask
    initial begin
        rst = 1'h1;
        {aw_v, w_v, ar_v, halt_req, pc_lvl} = 5'h0;
        // responses are always accepted, so no ready is ever toggled
        {b_rdy, r_rdy} = 2'h3;
        {aw_a, w_d, ar_a} = 96'h0;
        ext_lvl = 1'h1;
        adc_en = 1'h1;
        wake = '0;
        cyc(10);
        rst <= 1'h0;
        @(posedge clk);
        t_regs();
        t_noop();
        t_ext();
        t_wake(2'h0);
        t_wake(2'h1);
        t_pdown();
        t_reset();
        summarize();
    end
endmodule
